// >>> include/isf_cfg.svh
// What this block does
// - Host writing one to a status bit clears it; writing zero leaves it.
// - Software flag, bit 31, sets when software enable goes high.
// - Bit 25 sets once a stop was requested and the transmitter halted.
// - Bit 24 sets when the receiver halts.
// - Bit 23 sets when the dropped-frame counter top bit first becomes set.
// - Bit 21 sets when a marked transmit buffer is fully loaded.
// - Bit 20 sets when the programmed receive DMA amount was read out.
// - Bit 19 sets when the timer wraps from zero to FFFF.
// - Bit 18 is read-only and follows the PHY event source.
// - Bit 17 sets on power events regardless of the external signal.
// - Power events never wake; only a write to byte test does.
// - Hold-off interval never delays the power-event interrupt.
// - Bit 16 sets on a push into a full transmit status FIFO.
// - Bit 15 sets when a received packet exceeds 2048 bytes.
// - Bit 14 sets whenever the receiver reports an error.
// - Bit 13 sets whenever the transmitter reports an error.
// - Bit 11 sets when the transmit data FIFO underruns.
// - Bit 10 sets when the host writes a full transmit data FIFO.
// - Bit 9 sets when transmit free space exceeds its threshold.
// - Bit 8 on transmit status full, bit 7 on its level.
// - Bit 6 sets each time a received frame is dropped.
// - Bits 5, 4, 3 on receive data level, status full, status level.
// - Bits 2 to 0 latch pin events with configured trigger edge.
// - Flags record events even when their enable bit is clear.
// - Master indication is high while any enabled flag is set.
`ifndef ISF_CFG_SVH
`define ISF_CFG_SVH

`define ISF_FLAGS_OFF     8'h58
`define ISF_BYTE_TEST_OFF 8'h64

`define ISF_BIT_SW        31
`define ISF_BIT_TXSTOP    25
`define ISF_BIT_RXSTOP    24
`define ISF_BIT_DROPHALF  23
`define ISF_BIT_TXDONE    21
`define ISF_BIT_RXDMA     20
`define ISF_BIT_TIMER     19
`define ISF_BIT_PHY       18
`define ISF_BIT_POWER     17
`define ISF_BIT_TSOVF     16
`define ISF_BIT_RXWDT     15
`define ISF_BIT_RXERR     14
`define ISF_BIT_TXERR     13
`define ISF_BIT_TDUNDER   11
`define ISF_BIT_TDOVER    10
`define ISF_BIT_TDSPACE   9
`define ISF_BIT_TSFULL    8
`define ISF_BIT_TSLEVEL   7
`define ISF_BIT_DROP      6
`define ISF_BIT_RDLEVEL   5
`define ISF_BIT_RSFULL    4
`define ISF_BIT_RSLEVEL   3
`define ISF_BIT_PIN_LO    0

`define ISF_FLAGS_RESET   32'h0000_0000
`define ISF_LATCH_MASK    32'h83BB_EFFF
`define ISF_POWER_MASK    32'h0002_0000
`define ISF_WDT_BYTES     2048
`define ISF_TIMER_MAX     16'hFFFF

`endif

// >>> include/isf_pin_if.sv
`timescale 1ns/1ns
`default_nettype none
interface isf_pin_if #(parameter int PINS = 3);
  logic [PINS-1:0] level;
  logic [PINS-1:0] trigger;
  logic [PINS-1:0] event_hit;
  modport edge_side (input level, input trigger, output event_hit);
  modport top_side  (output level, output trigger, input event_hit);
endinterface
`default_nettype wire

// >>> include/isf_pkg.sv
package isf_pkg;
  typedef logic [31:0] isf_word_t;
  typedef logic [7:0]  isf_addr_t;
  typedef enum logic {
    ISF_TRIG_RISE = 1'b0,
    ISF_TRIG_FALL = 1'b1
  } isf_trig_t;
endpackage

// >>> src/isf_pin_edge.sv
`timescale 1ns/1ns
`default_nettype none
module isf_pin_edge
  import isf_pkg::*;
#(
  parameter int PINS = 3
) (
  input  wire logic  clk,
  input  wire logic  rst,
  isf_pin_if.edge_side pins
);
  logic [PINS-1:0] sync_a;
  logic [PINS-1:0] sync_b;
  logic [PINS-1:0] prev;
  logic [PINS-1:0] hit;

  // Two-flop synchroniser for the asynchronous pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= pins.level;
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev <= '0;
    end else begin
      prev <= sync_b;
    end
  end

  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (pins.trigger[i] == ISF_TRIG_FALL) begin
        hit[i] = prev[i] & ~sync_b[i];
      end else begin
        hit[i] = ~prev[i] & sync_b[i];
      end
    end
  end

  assign pins.event_hit = hit;
endmodule
`default_nettype wire

// >>> src/isf_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "isf_cfg.svh"
module isf_top
  import isf_pkg::*;
#(
  parameter int PINS   = 3,
  parameter int DMA_W  = 12,
  parameter int LEN_W  = 14,
  parameter int LVL_W  = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  // Register port
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire isf_addr_t        reg_addr,
  input  wire isf_word_t        reg_wdata,
  output isf_word_t             reg_rdata,
  // Enable mask held elsewhere
  input  wire isf_word_t        irq_enable,
  // Transmitter and receiver
  input  wire logic             tx_stop_request,
  input  wire logic             tx_halted,
  input  wire logic             rx_halted,
  input  wire logic             tx_error,
  input  wire logic             rx_error,
  input  wire logic             drop_count_msb,
  input  wire logic             frame_dropped,
  input  wire logic             tx_buffer_loaded,
  input  wire logic             completion_notify_mark,
  input  wire logic             rx_frame_end,
  input  wire logic [LEN_W-1:0] rx_frame_bytes,
  // Receive DMA
  input  wire logic             rx_dma_load,
  input  wire logic [DMA_W-1:0] receive_dma_length,
  input  wire logic             rx_fifo_pop,
  // Timer, PHY, power
  input  wire logic [15:0]      timer_value,
  input  wire logic             phy_event,
  input  wire logic             power_event_detect,
  // FIFO state
  input  wire logic             tx_data_write,
  input  wire logic             tx_data_full,
  input  wire logic             tx_data_empty_need,
  input  wire logic [LVL_W-1:0] tx_free_blocks,
  input  wire logic [LVL_W-1:0] tx_space_level,
  input  wire logic             tx_status_push,
  input  wire logic             tx_status_full,
  input  wire logic [LVL_W-1:0] tx_status_used,
  input  wire logic [LVL_W-1:0] tx_status_level,
  input  wire logic [LVL_W-1:0] rx_free_blocks,
  input  wire logic [LVL_W-1:0] rx_space_level,
  input  wire logic             rx_status_full,
  input  wire logic [LVL_W-1:0] rx_status_used,
  input  wire logic [LVL_W-1:0] rx_status_level,
  // Pin events
  input  wire logic [PINS-1:0]  gpio_pins,
  input  wire logic [PINS-1:0]  gpio_trigger,
  // Outputs
  output logic                  irq_master,
  output logic                  irq_deferrable,
  output logic                  irq_power,
  output logic                  device_wake
);

  isf_word_t flags;
  isf_word_t next_flags;
  isf_word_t level_src;
  isf_word_t level_prev;
  isf_word_t pulse_src;
  isf_word_t set_vec;
  isf_word_t clr_vec;
  isf_word_t view;
  logic [15:0]      timer_prev;
  logic [DMA_W-1:0] dma_left;
  logic             dma_armed;
  logic             dma_done;
  logic             flags_wr;
  logic             test_wr;

  isf_pin_if #(.PINS(PINS)) pin_bus ();

  isf_pin_edge #(
    .PINS (PINS)
  ) u_pin_edge (
    .clk  (clk),
    .rst  (rst),
    .pins (pin_bus.edge_side)
  );

  assign pin_bus.level   = gpio_pins;
  assign pin_bus.trigger = gpio_trigger;

  // Rising-edge test shared by all level-type sources
  function automatic isf_word_t isf_rise(input isf_word_t cur, input isf_word_t old);
    return cur & ~old;
  endfunction

  // Readable image: stored flags plus the live PHY bit
  function automatic isf_word_t isf_image(input isf_word_t f, input logic phy);
    isf_word_t v;
    v = f & `ISF_LATCH_MASK;
    v[`ISF_BIT_PHY] = phy;
    return v;
  endfunction

  assign flags_wr = reg_wr && (reg_addr == `ISF_FLAGS_OFF);
  assign test_wr  = reg_wr && (reg_addr == `ISF_BYTE_TEST_OFF);

  // Conditions that set a flag on their rising edge
  always_comb begin
    level_src = '0;
    level_src[`ISF_BIT_SW]       = irq_enable[`ISF_BIT_SW];
    level_src[`ISF_BIT_TXSTOP]   = tx_stop_request & tx_halted;
    level_src[`ISF_BIT_RXSTOP]   = rx_halted;
    level_src[`ISF_BIT_DROPHALF] = drop_count_msb;
    level_src[`ISF_BIT_TDSPACE]  = tx_free_blocks > tx_space_level;
    level_src[`ISF_BIT_TSFULL]   = tx_status_full;
    level_src[`ISF_BIT_TSLEVEL]  = tx_status_used > tx_status_level;
    level_src[`ISF_BIT_RDLEVEL]  = rx_free_blocks < rx_space_level;
    level_src[`ISF_BIT_RSFULL]   = rx_status_full;
    level_src[`ISF_BIT_RSLEVEL]  = rx_status_used > rx_status_level;
  end

  // Events that set a flag in the cycle they occur
  always_comb begin
    pulse_src = '0;
    pulse_src[`ISF_BIT_TXDONE] = tx_buffer_loaded & completion_notify_mark;
    pulse_src[`ISF_BIT_RXDMA]  = dma_done;
    pulse_src[`ISF_BIT_TIMER]  = (timer_prev == 16'h0000)
                                 && (timer_value == `ISF_TIMER_MAX);
    pulse_src[`ISF_BIT_POWER]  = power_event_detect;
    pulse_src[`ISF_BIT_TSOVF]  = tx_status_push & tx_status_full;
    pulse_src[`ISF_BIT_RXWDT]  = rx_frame_end
                                 && (rx_frame_bytes > LEN_W'(`ISF_WDT_BYTES));
    pulse_src[`ISF_BIT_RXERR]  = rx_error;
    pulse_src[`ISF_BIT_TXERR]  = tx_error;
    pulse_src[`ISF_BIT_TDUNDER] = tx_data_empty_need;
    pulse_src[`ISF_BIT_TDOVER] = tx_data_write & tx_data_full;
    pulse_src[`ISF_BIT_DROP]   = frame_dropped;
    pulse_src[`ISF_BIT_PIN_LO +: PINS] = pin_bus.event_hit;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_prev <= '0;
    end else begin
      level_prev <= level_src;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_prev <= 16'h0000;
    end else begin
      timer_prev <= timer_value;
    end
  end

  // Receive DMA countdown; done fires on the last programmed pop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dma_left  <= '0;
      dma_armed <= 1'b0;
      dma_done  <= 1'b0;
    end else begin
      dma_done <= 1'b0;
      if (rx_dma_load) begin
        dma_left  <= receive_dma_length;
        dma_armed <= (receive_dma_length != '0);
      end else if (dma_armed && rx_fifo_pop) begin
        dma_left <= dma_left - DMA_W'(1);
        if (dma_left == DMA_W'(1)) begin
          dma_armed <= 1'b0;
          dma_done  <= 1'b1;
        end
      end
    end
  end

  // Enable bits play no part here: flags always record
  assign set_vec = (pulse_src | isf_rise(level_src, level_prev)) & `ISF_LATCH_MASK;
  assign clr_vec = flags_wr ? (reg_wdata & `ISF_LATCH_MASK) : '0;

  // A set in the same cycle as the clear wins
  always_comb begin
    next_flags = ((flags & ~clr_vec) | set_vec) & `ISF_LATCH_MASK;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags <= `ISF_FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  assign view = isf_image(flags, phy_event);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= (reg_addr == `ISF_FLAGS_OFF) ? view : '0;
    end
  end

  // Master line ignores hold-off and output enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_master <= 1'b0;
    end else begin
      irq_master <= |(view & irq_enable);
    end
  end

  // Power event kept apart so hold-off never reaches it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_deferrable <= 1'b0;
      irq_power      <= 1'b0;
    end else begin
      irq_deferrable <= |(view & irq_enable & ~`ISF_POWER_MASK);
      irq_power      <= view[`ISF_BIT_POWER] & irq_enable[`ISF_BIT_POWER];
    end
  end

  // Wake comes only from a byte-test write, never a power event
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      device_wake <= 1'b0;
    end else begin
      device_wake <= test_wr;
    end
  end

endmodule
`default_nettype wire

// >>> tb/isf_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module isf_assertions
  import isf_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire isf_addr_t   reg_addr,
  input wire isf_word_t   reg_rdata,
  input wire isf_word_t   irq_enable,
  input wire logic        rx_error,
  input wire logic        power_event_detect,
  input wire logic [15:0] timer_value,
  input wire logic        phy_event,
  input wire logic        irq_master,
  input wire logic        irq_deferrable,
  input wire logic        irq_power,
  input wire logic        device_wake
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  phy_live_a: assert property (reg_rd && reg_addr == 8'h58
    |=> reg_rdata[18] == $past(phy_event)) else $error("phy bit not live");
  reserved_zero_a: assert property (reg_rd |=> (reg_rdata & 32'h7C40_1000) == 32'h0)
    else $error("reserved bit read as one");
  unmapped_zero_a: assert property (reg_rd && reg_addr != 8'h58 && reg_addr != 8'h64
    |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
  wake_write_a: assert property (reg_wr && reg_addr == 8'h64 |=> device_wake)
    else $error("no wake after byte test write");
  wake_only_a: assert property (!(reg_wr && reg_addr == 8'h64) |=> !device_wake)
    else $error("wake without byte test write");
  rx_err_irq_a: assert property (rx_error && irq_enable[14] ##1 irq_enable[14]
    |=> irq_master && irq_deferrable) else $error("receiver error not signalled");
  power_irq_a: assert property (power_event_detect && irq_enable[17] ##1 irq_enable[17]
    |=> irq_power && irq_master) else $error("power event not signalled");
  timer_irq_a: assert property (timer_value == 16'h0 ##1 timer_value == 16'hFFFF
    && irq_enable[19] ##1 irq_enable[19] |=> irq_master) else $error("timer wrap missed");
  power_subset_a: assert property (irq_power |-> irq_master)
    else $error("power line without master");
  masked_quiet_a: assert property (irq_enable == 32'h0 |=> !irq_master)
    else $error("master raised while all masked");
  cover property (device_wake);
  cover property (irq_power && !irq_deferrable);
  cover property (reg_rd && reg_addr == 8'h58);
endmodule
bind isf_top isf_assertions chk (
  .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .irq_enable(irq_enable), .rx_error(rx_error),
  .power_event_detect(power_event_detect), .timer_value(timer_value), .phy_event(phy_event),
  .irq_master(irq_master), .irq_deferrable(irq_deferrable), .irq_power(irq_power),
  .device_wake(device_wake)
);
`default_nettype wire

// >>> tb/isf_host.sv
`timescale 1ns/1ns
`default_nettype none
module isf_host
  import isf_pkg::*;
(
  input  wire logic      clk,
  input  wire isf_word_t reg_rdata,
  output logic           reg_wr,
  output logic           reg_rd,
  output isf_addr_t      reg_addr,
  output isf_word_t      reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'hFF;
    reg_wdata = 32'h0;
  end
  // Released address and data are inverted so stale values cannot pass
  task automatic wr(input isf_addr_t a, input isf_word_t d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input isf_addr_t a, output isf_word_t d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// >>> tb/isf_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "isf_cfg.svh"
module isf_test
  import isf_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  isf_word_t   ev = 32'h0;
  isf_word_t   en = 32'h0;
  isf_word_t   v;
  logic [15:0] tmr = 16'h0;
  logic [13:0] len = 14'h801;
  logic [2:0]  trg = 3'h0;
  logic        dl = 1'b0, pp = 1'b0, phy = 1'b0, mk = 1'b1, sr = 1'b1;
  int          failures = 0, n_tests = 0, cyc = 0, wakes = 0;
  wire logic   reg_wr, reg_rd, irq_master, irq_deferrable, irq_power, device_wake;
  wire isf_addr_t reg_addr;
  wire isf_word_t reg_wdata, reg_rdata;
  isf_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  isf_top dut (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_enable(en | {ev[31], 31'h0}),
    .tx_stop_request(sr), .tx_halted(ev[25]), .rx_halted(ev[24]), .tx_error(ev[13]),
    .rx_error(ev[14]), .drop_count_msb(ev[23]), .frame_dropped(ev[6]),
    .tx_buffer_loaded(ev[21]), .completion_notify_mark(mk), .rx_frame_end(ev[15]),
    .rx_frame_bytes(len), .rx_dma_load(dl), .receive_dma_length(12'h002),
    .rx_fifo_pop(pp), .timer_value(tmr), .phy_event(phy), .power_event_detect(ev[17]),
    .tx_data_write(ev[10]), .tx_data_full(ev[10]), .tx_data_empty_need(ev[11]),
    .tx_free_blocks({6'h0, ev[9], 1'b0}), .tx_space_level(8'h01),
    .tx_status_push(ev[16]), .tx_status_full(ev[8] | ev[16]),
    .tx_status_used({6'h0, ev[7], 1'b0}), .tx_status_level(8'h01),
    .rx_free_blocks({6'h0, ~ev[5], 1'b0}), .rx_space_level(8'h01),
    .rx_status_full(ev[4]), .rx_status_used({6'h0, ev[3], 1'b0}),
    .rx_status_level(8'h01), .gpio_pins(ev[2:0]), .gpio_trigger(trg),
    .irq_master(irq_master), .irq_deferrable(irq_deferrable), .irq_power(irq_power),
    .device_wake(device_wake)
  );
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic complete_run;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (device_wake === 1'b1) wakes++;
    if (cyc == 3000) begin
      failures++;
      complete_run();
    end
  end
  task automatic chk(input isf_word_t got, input isf_word_t exp, input string m);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rdchk(input isf_word_t exp, input string m);
    host.rd(8'h58, v);
    chk(v, exp, m);
  endtask
  task automatic pulse(input int b);
    @(negedge clk);
    ev[b] = 1'b1;
    @(negedge clk);
    ev[b] = 1'b0;
  endtask
  task automatic test_reset;
    rdchk(32'h0, "flags after reset");
    host.rd(8'h50, v);
    chk(v, 32'h0, "unmapped read");
    $display("test reset done");
  endtask
  task automatic test_sources;
    isf_word_t e;
    for (int b = 0; b < 32; b++) begin
      if (b != 19 && b != 20 && (`ISF_LATCH_MASK & (32'h1 << b)) != 32'h0) begin
        e = 32'h1 << b;
        e[8] = e[8] | (b == 16);
        pulse(b);
        repeat (5) @(negedge clk);
        rdchk(e, "flag set with mask clear");
        host.wr(8'h58, 32'h0);
        rdchk(e, "zero write keeps flag");
        host.wr(8'h58, e);
        rdchk(32'h0, "one write clears flag");
      end
    end
    $display("test sources done");
  endtask
  task automatic test_special;
    len = 14'h800;
    sr = 1'b0;
    mk = 1'b0;
    pulse(15);
    pulse(25);
    pulse(21);
    repeat (3) @(negedge clk);
    rdchk(32'h0, "flag without cause");
    len = 14'h801;
    sr = 1'b1;
    mk = 1'b1;
    dl = 1'b1;
    @(negedge clk);
    dl = 1'b0;
    pp = 1'b1;
    @(negedge clk);
    pp = 1'b0;
    repeat (3) @(negedge clk);
    rdchk(32'h0, "dma count not reached");
    pp = 1'b1;
    @(negedge clk);
    pp = 1'b0;
    repeat (3) @(negedge clk);
    rdchk(32'h0010_0000, "dma count reached");
    host.wr(8'h58, 32'hFFFF_FFFF);
    rdchk(32'h0, "reserved stay zero");
    $display("test special done");
  endtask
  task automatic test_phy;
    phy = 1'b1;
    rdchk(32'h0004_0000, "phy bit follows source");
    host.wr(8'h58, 32'h0004_0000);
    rdchk(32'h0004_0000, "phy bit ignores write");
    phy = 1'b0;
    rdchk(32'h0, "phy bit drops");
    $display("test phy done");
  endtask
  // Falling trigger: a rising pin must be ignored, the drop latched
  task automatic test_falling;
    trg = 3'h7;
    @(negedge clk);
    ev[1] = 1'b1;
    repeat (5) @(negedge clk);
    rdchk(32'h0, "rising pin ignored on falling trigger");
    ev[1] = 1'b0;
    repeat (5) @(negedge clk);
    rdchk(32'h0000_0002, "falling pin edge latched");
    host.wr(8'h58, 32'h0000_0002);
    rdchk(32'h0, "pin flag cleared");
    trg = 3'h0;
    $display("test falling done");
  endtask
  task automatic test_irq;
    en = 32'h000A_4000;
    pulse(14);
    pulse(17);
    @(negedge clk);
    tmr = 16'hFFFF;
    repeat (3) @(negedge clk);
    chk({29'h0, irq_master, irq_deferrable, irq_power}, 32'h7, "lines raised");
    host.wr(8'h58, 32'h0008_4000);
    repeat (2) @(negedge clk);
    chk({29'h0, irq_master, irq_deferrable, irq_power}, 32'h5, "power alone");
    en = 32'h0;
    repeat (2) @(negedge clk);
    chk({29'h0, irq_master, irq_deferrable, irq_power}, 32'h0, "masked quiet");
    rdchk(32'h0002_0000, "flag stays while masked");
    host.wr(8'h58, 32'h0002_0000);
    rdchk(32'h0, "power flag cleared");
    tmr = 16'h0;
    $display("test irq done");
  endtask
  task automatic test_wake;
    chk(isf_word_t'(wakes), 32'h0, "power events do not wake");
    host.wr(8'h64, 32'h1234_5678);
    @(negedge clk);
    chk(isf_word_t'(wakes), 32'h1, "wake after byte test write");
    $display("test wake done");
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    test_reset();
    test_sources();
    test_special();
    test_phy();
    test_falling();
    test_irq();
    test_wake();
    complete_run();
  end
endmodule
`default_nettype wire
